// ===== rtl/lcb_defs.svh
/*
  Constants for the local processor port: function codes, interrupt levels,
  reset values and clock figures. Assumes a single 25 MHz system clock.
*/
`ifndef LCB_DEFS_SVH
`define LCB_DEFS_SVH

// Clock figures in their own units.
`define LCB_MCLK_PERIOD_NS   40
`define LCB_CARD_CLK_MHZ     10

// Function code seen during an interrupt acknowledge cycle.
`define LCB_IACK_CODE        2'h3

// Interrupt levels, as plain priority numbers.
`define LCB_LVL_NONE         2'h0
`define LCB_LVL_TIMER        2'h1
`define LCB_LVL_BACKPLANE    2'h2
`define LCB_LVL_IO           2'h3

// Idle levels of the active-low pins.
`define LCB_PRIO_IDLE        2'h3
`define LCB_PIN_IDLE         1'h1

`endif

// ===== rtl/lcb_pkg.sv
/*
  Types shared by the local processor port: bus owner states, register
  access sizes, backplane request bundle and the state record of the port.
  Assumes the constants header is included by the design files.
*/
package lcb_pkg;

  // Who owns the local bus this cycle.
  typedef enum logic [2:0] {
    OWN_IDLE = 3'h1,
    OWN_BP   = 3'h2,
    OWN_CPU  = 3'h4
  } owner_e;

  // Register access size chosen by the processor's byte strobes.
  typedef enum logic [2:0] {
    SZ_NONE = 3'h1,
    SZ_LOW  = 3'h2,
    SZ_WORD = 3'h4
  } reg_size_e;

  // Local-bus request made on behalf of the backplane.
  typedef struct packed {
    logic active;  // Cycle in progress.
    logic word;    // 16-bit transfer.
    logic odd;     // Odd byte when not a word.
    logic read;    // Read when high.
  } bp_req_s;

  // One driven pin: level and output enable.
  typedef struct packed {
    logic o;
    logic oe;
  } pin_s;

  // Complete state of the port.
  typedef struct packed {
    owner_e    own;
    logic [1:0] lvl;
    logic [1:0] prio_n;
    pin_s      up_strb;
    pin_s      low_strb;
    pin_s      rd_wr;
    pin_s      ack;
    logic      dram_rw_n;
    logic      slow_n;
    reg_size_e size;
  } lcb_state_s;

endpackage

// ===== rtl/local_cpu_bus_interrupt_port.sv
/*
  Local processor side of a backplane interface controller: interrupt
  priority encoding, byte strobe and read/write direction, transfer
  acknowledge, slow peripheral select and the card clock.
  Assumes all inputs are synchronous to mclk and that an outside resolver
  forms pin levels from the level and enable pairs.
*/
`timescale 1ns/100ps
`include "lcb_defs.svh"

// Function
// (R1) Only both function codes high means acknowledge.
// (R2) External request raises level 3.
// (R3) Levels: timer 1, backplane 2, I/O 3.
// (R4) Inverted two-line encoding; top line undriven.
// (R5) Hold level until acknowledge cycle.
// (R6) Highest pending level wins.
// (R7) Drive byte strobes for backplane transfers.
// (R8) Processor strobes select byte or word.
// (R9) Drive symmetric card clock from phases.
// (R10) Card supplies two phase-shifted clocks.
// (R11) Drive read/write only for backplane cycles.
// (R12) Read/write high reads, low writes.
// (R13) Separate memory read/write, write only strobed.
// (R14) Flag slow peripheral addresses.
// (R15) No slow cycles for backplane accesses.
// (R16) Drive transfer acknowledge for processor accesses.
module local_cpu_bus_interrupt_port (
  input  wire logic              mclk,                // System clock, 25 MHz.
  input  wire logic              rst_b,               // Asynchronous reset, active low.
  input  wire logic [1:0]        func_code_in,        // Processor function code.
  input  wire logic              io_irq_in_n,         // External I/O request, active low.
  input  wire logic              timer_irq,           // Internal timer request.
  input  wire logic              bp_irq,              // Backplane request.
  input  wire lcb_pkg::bp_req_s  bp_req,              // Backplane local-bus request.
  input  wire logic              cpu_as_n,            // Processor address strobe.
  input  wire logic              cpu_reg_sel,         // Address hits controller space.
  input  wire logic              cpu_ready,           // Controller side done.
  input  wire logic              slow_addr_hit,       // Address hits slow peripheral.
  input  wire logic              rd_wr_in,            // Read/write pin input level.
  input  wire logic              up_byte_strobe_n_i,  // Upper strobe pin input.
  input  wire logic              low_byte_strobe_n_i, // Lower strobe pin input.
  input  wire logic              phase_clk_a,         // First phase clock.
  input  wire logic              phase_clk_b,         // Second phase clock.
  output logic [1:0]             irq_prio_out_n,      // Priority lines, active low.
  output lcb_pkg::pin_s          up_byte_strobe_n,    // Upper strobe drive.
  output lcb_pkg::pin_s          low_byte_strobe_n,   // Lower strobe drive.
  output lcb_pkg::pin_s          rd_wr_n,             // Read/write drive.
  output lcb_pkg::pin_s          xfer_ack_n,          // Transfer acknowledge drive.
  output logic                   dram_rd_wr_n,        // Memory read/write.
  output logic                   slow_periph_sel_n,   // Slow peripheral select.
  output lcb_pkg::reg_size_e     reg_size,            // Register access size.
  output logic                   card_clk_out         // Card clock.
);
  import lcb_pkg::*;

  lcb_state_s st_ff;
  lcb_state_s nxt_st;
  logic       iack;
  logic [1:0] pend_lvl;

  // (R1) acknowledge decode
  assign iack = (func_code_in == `LCB_IACK_CODE);

  // (R6) highest pending level
  // (R2) I/O request maps to level 3; (R3) levels per source.
  always_comb begin
    if (!io_irq_in_n) begin
      pend_lvl = `LCB_LVL_IO;
    end else if (bp_irq) begin
      pend_lvl = `LCB_LVL_BACKPLANE;
    end else if (timer_irq) begin
      pend_lvl = `LCB_LVL_TIMER;
    end else begin
      pend_lvl = `LCB_LVL_NONE;
    end
  end

  // Next state of the whole port.
  always_comb begin
    nxt_st = st_ff;
    // (R5) hold until acknowledge
    // A new level is not loaded during the acknowledge cycle itself, so a
    // request that is still pending shows again right after it ends.
    if (st_ff.lvl != `LCB_LVL_NONE) begin
      if (iack) begin
        nxt_st.lvl = `LCB_LVL_NONE;
      end
    end else if (!iack) begin
      nxt_st.lvl = pend_lvl;
    end
    // (R4) inverted priority encoding
    nxt_st.prio_n = ~nxt_st.lvl;

    // Bus ownership. The backplane wins when both arrive together.
    unique case (st_ff.own)
      OWN_IDLE: begin
        if (bp_req.active) begin
          nxt_st.own = OWN_BP;
        end else if (!cpu_as_n && cpu_reg_sel) begin
          nxt_st.own = OWN_CPU;
        end
      end
      OWN_BP: begin
        if (!bp_req.active) begin
          nxt_st.own = OWN_IDLE;
        end
      end
      OWN_CPU: begin
        if (cpu_as_n) begin
          nxt_st.own = OWN_IDLE;
        end
      end
      default: begin
        nxt_st.own = OWN_IDLE;
      end
    endcase

    // (R7) backplane byte strobes
    nxt_st.up_strb.oe  = (nxt_st.own == OWN_BP);
    nxt_st.low_strb.oe = (nxt_st.own == OWN_BP);
    nxt_st.up_strb.o   = !(nxt_st.up_strb.oe && (bp_req.word || !bp_req.odd));
    nxt_st.low_strb.o  = !(nxt_st.low_strb.oe && (bp_req.word || bp_req.odd));

    // (R11) read/write direction
    // (R12) high reads, low writes
    nxt_st.rd_wr.oe = (nxt_st.own == OWN_BP);
    nxt_st.rd_wr.o  = nxt_st.rd_wr.oe ? bp_req.read : `LCB_PIN_IDLE;

    // (R13) memory read/write
    // Low only while a write strobe is out, so refresh-only cycles with
    // no strobe always see a read level.
    if (nxt_st.own == OWN_BP) begin
      nxt_st.dram_rw_n = bp_req.read || (nxt_st.up_strb.o && nxt_st.low_strb.o);
    end else begin
      nxt_st.dram_rw_n = rd_wr_in ||
                         (up_byte_strobe_n_i && low_byte_strobe_n_i);
    end

    // (R8) register access size
    // An upper-byte-only access is not a register operation here.
    nxt_st.size = SZ_NONE;
    if (nxt_st.own == OWN_CPU) begin
      if (!up_byte_strobe_n_i && !low_byte_strobe_n_i) begin
        nxt_st.size = SZ_WORD;
      end else if (!low_byte_strobe_n_i) begin
        nxt_st.size = SZ_LOW;
      end
    end

    // (R16) transfer acknowledge
    // Once given, the acknowledge stays low until the address strobe ends.
    nxt_st.ack.oe = (nxt_st.own == OWN_CPU);
    if (!nxt_st.ack.oe) begin
      nxt_st.ack.o = `LCB_PIN_IDLE;
    end else if (cpu_ready) begin
      nxt_st.ack.o = 1'h0;
    end

    // (R14) slow peripheral select
    // (R15) never for backplane
    nxt_st.slow_n = !(!cpu_as_n && slow_addr_hit && nxt_st.own != OWN_BP &&
                      !bp_req.active);
  end

  // State register.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      st_ff           <= '0;
      st_ff.own       <= OWN_IDLE;
      st_ff.prio_n    <= `LCB_PRIO_IDLE;
      st_ff.up_strb   <= '{o: `LCB_PIN_IDLE, oe: 1'h0};
      st_ff.low_strb  <= '{o: `LCB_PIN_IDLE, oe: 1'h0};
      st_ff.rd_wr     <= '{o: `LCB_PIN_IDLE, oe: 1'h0};
      st_ff.ack       <= '{o: `LCB_PIN_IDLE, oe: 1'h0};
      st_ff.dram_rw_n <= `LCB_PIN_IDLE;
      st_ff.slow_n    <= `LCB_PIN_IDLE;
      st_ff.size      <= SZ_NONE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // (R9) symmetric card clock
  phase_clk_gen u_phase_clk_gen (
    .mclk         (mclk),
    .rst_b        (rst_b),
    .phase_clk_a  (phase_clk_a),
    .phase_clk_b  (phase_clk_b),
    .card_clk_out (card_clk_out)
  );

  // Outputs come straight from the state register.
  assign irq_prio_out_n    = st_ff.prio_n;
  assign up_byte_strobe_n  = st_ff.up_strb;
  assign low_byte_strobe_n = st_ff.low_strb;
  assign rd_wr_n           = st_ff.rd_wr;
  assign xfer_ack_n        = st_ff.ack;
  assign dram_rd_wr_n      = st_ff.dram_rw_n;
  assign slow_periph_sel_n = st_ff.slow_n;
  assign reg_size          = st_ff.size;

  // Checks on the port's own behaviour.
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);

  chk_iack_clears_level: assert property ( // (R1)
    (st_ff.lvl != `LCB_LVL_NONE && iack) |=> irq_prio_out_n == `LCB_PRIO_IDLE)
    else $error("Acknowledge did not clear the priority lines.");

  chk_io_level_three: assert property ( // (R2)
    (st_ff.lvl == `LCB_LVL_NONE && !iack && !io_irq_in_n) |=> irq_prio_out_n == 2'h0)
    else $error("I/O request did not give level three.");

  chk_timer_level_one: assert property ( // (R3)
    (st_ff.lvl == `LCB_LVL_NONE && !iack && timer_irq && !bp_irq && io_irq_in_n)
    |=> irq_prio_out_n == 2'h2)
    else $error("Timer request did not give level one.");

  chk_prio_encoding: assert property ( // (R4)
    irq_prio_out_n == ~st_ff.lvl)
    else $error("Priority lines are not the inverted level.");

  chk_level_holds: assert property ( // (R5)
    (irq_prio_out_n != `LCB_PRIO_IDLE && !iack) |=> $stable(irq_prio_out_n))
    else $error("Priority lines changed before acknowledge.");

  chk_bp_over_timer: assert property ( // (R6)
    (st_ff.lvl == `LCB_LVL_NONE && !iack && bp_irq && io_irq_in_n)
    |=> irq_prio_out_n == 2'h1)
    else $error("Backplane request lost to a lower level.");

  chk_bp_strobes: assert property ( // (R7)
    (st_ff.own == OWN_IDLE && bp_req.active && bp_req.word)
    |=> !up_byte_strobe_n.o && up_byte_strobe_n.oe && !low_byte_strobe_n.o)
    else $error("Word transfer did not drive both strobes.");

  chk_cpu_strobes_in: assert property ( // (R8)
    st_ff.own == OWN_CPU |-> !up_byte_strobe_n.oe && !low_byte_strobe_n.oe)
    else $error("Strobes driven during a processor access.");

  chk_rw_direction: assert property ( // (R11)
    rd_wr_n.oe |-> st_ff.own == OWN_BP ##0 rd_wr_n.o == $past(bp_req.read))
    else $error("Read/write driven outside a backplane cycle.");

  chk_dram_read_idle: assert property ( // (R13)
    (st_ff.own == OWN_BP && up_byte_strobe_n.o && low_byte_strobe_n.o) |-> dram_rd_wr_n)
    else $error("Memory write level with no strobe.");

  chk_no_slow_bp: assert property ( // (R15)
    st_ff.own == OWN_BP |-> slow_periph_sel_n)
    else $error("Slow peripheral select during a backplane cycle.");

  chk_ack_held: assert property ( // (R16)
    (!xfer_ack_n.o && !cpu_as_n) |=> !xfer_ack_n.o)
    else $error("Acknowledge dropped while the strobe was held.");

  // Further checks on refused loads, transfer sizes, slow select and the clock.

  chk_no_load_iack: assert property ( // (R1)
    (st_ff.lvl == `LCB_LVL_NONE && iack) |=> irq_prio_out_n == `LCB_PRIO_IDLE)
    else $error("A level was loaded during an acknowledge cycle.");

  chk_bp_byte_one: assert property ( // (R7)
    (st_ff.own == OWN_IDLE && bp_req.active && !bp_req.word)
    |=> up_byte_strobe_n.o != low_byte_strobe_n.o)
    else $error("Byte transfer did not drive exactly one strobe.");

  chk_cpu_word_size: assert property ( // (R8)
    (st_ff.own == OWN_CPU && !cpu_as_n && !up_byte_strobe_n_i && !low_byte_strobe_n_i)
    |=> reg_size == SZ_WORD)
    else $error("Both strobes low did not give a word access.");

  chk_bp_write_low: assert property ( // (R12)
    (st_ff.own == OWN_IDLE && bp_req.active && !bp_req.read)
    |=> rd_wr_n.oe && !rd_wr_n.o)
    else $error("Backplane write did not drive the line low.");

  chk_slow_select: assert property ( // (R14)
    (!cpu_as_n && slow_addr_hit && !bp_req.active) |=> !slow_periph_sel_n)
    else $error("Slow peripheral address was not flagged.");

  chk_ack_on_ready: assert property ( // (R16)
    (st_ff.own == OWN_CPU && !cpu_as_n && cpu_ready)
    |=> xfer_ack_n.oe && !xfer_ack_n.o)
    else $error("Ready did not give the transfer acknowledge.");

  // The release edge still resets the clock register, so it is left out.
  chk_card_clk_low: assert property ( // (R9)
    (rst_b && !phase_clk_a) |=> !card_clk_out)
    else $error("Card clock not low after the first phase.");

  chk_card_clk_high: assert property ( // (R9)
    (rst_b && !phase_clk_b) |=> card_clk_out)
    else $error("Card clock not high after the second phase.");

  cov_iack_cycle: cover property (
    st_ff.lvl == `LCB_LVL_IO ##[1:20] iack);
  cov_bp_byte: cover property (
    st_ff.own == OWN_BP && !bp_req.word && !bp_req.read);
  cov_cpu_word_ack: cover property (
    st_ff.size == SZ_WORD && !xfer_ack_n.o);
  cov_slow_sel: cover property (
    !slow_periph_sel_n);
  cov_card_clk_rise: cover property (
    $rose(card_clk_out));

endmodule

// ===== rtl/phase_clk_gen.sv
/*
  Derives a symmetric card clock from two phase-shifted 10 MHz clocks.
  Assumes both inputs are synchronous to mclk and 50 ns apart, and that
  mclk runs at 40 ns, so samples step through the phase cycle 40 ns apart.
*/
`timescale 1ns/100ps

module phase_clk_gen (
  input  wire logic mclk,         // System clock.
  input  wire logic rst_b,        // Asynchronous reset, active low.
  input  wire logic phase_clk_a,  // Phase clock falling at 0 ns.
  input  wire logic phase_clk_b,  // Phase clock falling at 50 ns.
  output logic      card_clk_out  // Symmetric card clock.
);

  typedef struct packed {
    logic a_q;
    logic b_q;
    logic clk;
  } pcg_state_s;

  pcg_state_s st_ff;
  pcg_state_s nxt_st;

  // A low marks the low half, B low the high half. The 25 ns low pulses can
  // fall between two samples, so plain edge detection would lose them.
  // Two samples in a row with both phases high lie in opposite quarters,
  // so the clock toggles then and keeps step without seeing every pulse.
  always_comb begin
    nxt_st     = st_ff;
    nxt_st.a_q = phase_clk_a;
    nxt_st.b_q = phase_clk_b;
    if (!phase_clk_a) begin
      nxt_st.clk = 1'h0;
    end else if (!phase_clk_b) begin
      nxt_st.clk = 1'h1;
    end else if (st_ff.a_q && st_ff.b_q) begin
      nxt_st.clk = !st_ff.clk;
    end
  end

  // State register.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign card_clk_out = st_ff.clk;

endmodule

// ===== test/card_side_model.sv
/*
  Card-side model: the phase clock source and the shared pin resolver.
  Assumes the bench supplies the processor's own drive of the shared pins.
*/
`timescale 1ns/100ps

module card_side_model (
  input  wire lcb_pkg::pin_s up_drv,      // Controller upper strobe drive.
  input  wire lcb_pkg::pin_s low_drv,     // Controller lower strobe drive.
  input  wire lcb_pkg::pin_s rw_drv,      // Controller read/write drive.
  input  wire logic [2:0]    cpu_pins,    // Processor upper, lower, read/write.
  input  wire logic          cpu_oe,      // Processor drives the pins.
  output logic [2:0]         pin_lvl,     // Resolved upper, lower, read/write.
  output logic               phase_clk_a, // First phase clock.
  output logic               phase_clk_b  // Second phase clock.
);
  import lcb_pkg::*;

  // shared pin levels
  // Released pins float high through the pull-ups, so idle reads as no strobe.
  always_comb begin
    pin_lvl = cpu_oe ? cpu_pins : 3'h7;
    if (up_drv.oe) pin_lvl[2] = up_drv.o;
    if (low_drv.oe) pin_lvl[1] = low_drv.o;
    if (rw_drv.oe) pin_lvl[0] = rw_drv.o;
  end

  // phase clock timing
  // A 100 ns cycle; the first clock falls at 0 ns, the second at 50 ns.
  initial begin
    phase_clk_a = 1'h0;
    phase_clk_b = 1'h1;
    // Start 2 ns late so that no phase edge lands on a system clock edge.
    #2;
    forever begin
      phase_clk_a = 1'h0;
      #25 phase_clk_a = 1'h1;
      #25 phase_clk_b = 1'h0;
      #25 phase_clk_b = 1'h1;
      #25;
    end
  end
endmodule

// ===== test/tb.sv
/*
  Self-checking bench for the local processor port.
  Assumes the card-side model supplies the phase clocks and pin levels.
*/
`timescale 1ns/100ps
`include "lcb_defs.svh"

module tb;
  import lcb_pkg::*;
  logic mclk, rst_b, io_n, tmr, bpi, as_n, rsel, rdy, slow, cpu_oe;
  logic [1:0] fc, prio;
  logic [2:0] cpu_pins, pin_lvl;
  logic pa, pb, dram, slow_n, cclk;
  bp_req_s bpr;
  pin_s ups, lows, rw, ack;
  reg_size_e rsz;
  int bad_count = 0;
  int num_checks = 0;

  card_side_model u_card (.up_drv(ups), .low_drv(lows), .rw_drv(rw), .cpu_pins(cpu_pins),
    .cpu_oe(cpu_oe), .pin_lvl(pin_lvl), .phase_clk_a(pa), .phase_clk_b(pb));

  local_cpu_bus_interrupt_port u_dut (.mclk(mclk), .rst_b(rst_b), .func_code_in(fc),
    .io_irq_in_n(io_n), .timer_irq(tmr), .bp_irq(bpi), .bp_req(bpr), .cpu_as_n(as_n),
    .cpu_reg_sel(rsel), .cpu_ready(rdy), .slow_addr_hit(slow), .rd_wr_in(pin_lvl[0]),
    .up_byte_strobe_n_i(pin_lvl[2]), .low_byte_strobe_n_i(pin_lvl[1]), .phase_clk_a(pa),
    .phase_clk_b(pb), .irq_prio_out_n(prio), .up_byte_strobe_n(ups),
    .low_byte_strobe_n(lows), .rd_wr_n(rw), .xfer_ack_n(ack), .dram_rd_wr_n(dram),
    .slow_periph_sel_n(slow_n), .reg_size(rsz), .card_clk_out(cclk));

  // Free-running 25 MHz clock.
  initial begin
    mclk = 1'h0;
    forever #20 mclk = ~mclk;
  end

  // Compares one value and counts the result.
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Waits n edges and lets their updates settle.
  task automatic wt(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Acknowledges the shown level and expects the next one.
  task automatic iack_then(input logic [1:0] exp);
    @(posedge mclk) fc <= `LCB_IACK_CODE;
    wt(1);
    @(posedge mclk) fc <= 2'h0;
    wt(1);
    chk("prio next", prio, exp);
  endtask

  task automatic t_irq;
    @(posedge mclk) io_n <= 1'h0;
    wt(1);
    chk("prio io", prio, 2'h0);
    @(posedge mclk) io_n <= 1'h1;
    @(posedge mclk) fc <= 2'h2;
    wt(3);
    chk("prio held", prio, 2'h0);
    @(posedge mclk) fc <= 2'h1;
    wt(2);
    chk("prio fc01", prio, 2'h0);
    @(posedge mclk) begin
      fc <= `LCB_IACK_CODE;
      io_n <= 1'h0;
      tmr <= 1'h1;
      bpi <= 1'h1;
    end
    wt(1);
    chk("prio clear", prio, `LCB_PRIO_IDLE);
    @(posedge mclk) fc <= 2'h0;
    wt(1);
    chk("prio all", prio, 2'h0);
    @(posedge mclk) io_n <= 1'h1;
    iack_then(2'h1);
    @(posedge mclk) bpi <= 1'h0;
    iack_then(2'h2);
    @(posedge mclk) tmr <= 1'h0;
    iack_then(`LCB_PRIO_IDLE);
    $display("test irq done");
  endtask

  task automatic t_bp;
    logic [2:0] mode [3] = '{3'h5, 3'h0, 3'h3};
    logic [3:0] expv [3] = '{4'h3, 4'h4, 4'hb};
    for (int i = 0; i < 3; i++) begin
      @(posedge mclk) begin
        bpr <= {1'h1, mode[i]};
        as_n <= 1'h0;
        rsel <= 1'h1;
        slow <= 1'h1;
      end
      wt(1);
      chk("bp pins", {ups.o, lows.o, rw.o, dram}, expv[i]);
      chk("bp oe", {ups.oe, lows.oe, rw.oe, ack.oe}, 4'he);
      chk("bp slow", slow_n, 1'h1);
      @(posedge mclk) begin
        bpr <= 4'h0;
        as_n <= 1'h1;
        rsel <= 1'h0;
        slow <= 1'h0;
      end
      wt(1);
      chk("bp release", {ups.oe, lows.oe, rw.oe}, 3'h0);
      wt(1);
    end
    $display("test backplane done");
  endtask

  task automatic t_cpu;
    logic [2:0] pins [3] = '{3'h0, 3'h5, 3'h3};
    reg_size_e sz [3] = '{SZ_WORD, SZ_LOW, SZ_NONE};
    int n;
    for (int i = 0; i < 3; i++) begin
      @(posedge mclk) begin
        as_n <= 1'h0;
        rsel <= 1'h1;
        cpu_pins <= pins[i];
        cpu_oe <= 1'h1;
      end
      wt(1);
      chk("cpu oe", {ack.oe, rw.oe, ups.oe, lows.oe}, 4'h8);
      chk("cpu size", rsz, sz[i]);
      @(posedge mclk) rdy <= 1'h1;
      n = 0;
      do begin
        wt(1);
        n++;
      end while (ack.o !== 1'h0 && n < 5);
      chk("cpu ack", ack.o, 1'h0);
      chk("cpu dram", dram, pins[i][0]);
      @(posedge mclk) begin
        as_n <= 1'h1;
        rsel <= 1'h0;
        rdy <= 1'h0;
        cpu_oe <= 1'h0;
      end
      wt(1);
      chk("cpu end", {ack.o, ack.oe, rsz}, {2'h2, SZ_NONE});
      wt(1);
    end
    $display("test cpu done");
  endtask

  task automatic t_slow_clk;
    int rises = 0;
    int highs = 0;
    logic last;
    @(posedge mclk) begin
      as_n <= 1'h0;
      slow <= 1'h1;
    end
    wt(1);
    chk("slow on", slow_n, 1'h0);
    @(posedge mclk) as_n <= 1'h1;
    wt(1);
    chk("slow off", slow_n, 1'h1);
    last = cclk;
    repeat (50) begin
      wt(1);
      if (cclk && !last) rises++;
      if (cclk) highs++;
      last = cclk;
    end
    chk("clk rises", rises inside {[19:21]}, 1'h1);
    chk("clk duty", highs inside {[20:30]}, 1'h1);
    $display("test slow and clock done");
  endtask

  // Reset, then the scenarios in turn.
  initial begin
    {rst_b, io_n, tmr, bpi, as_n, rsel, rdy, slow, cpu_oe} = 9'h090;
    fc = 2'h0;
    cpu_pins = 3'h7;
    bpr = 4'h0;
    wt(5);
    chk("reset", {prio, ups, lows, rw, ack}, 10'h3aa);
    chk("reset misc", {dram, slow_n, rsz}, {2'h3, SZ_NONE});
    @(posedge mclk) rst_b <= 1'h1;
    t_irq();
    t_bp();
    t_cpu();
    t_slow_clk();
    tally_and_finish();
  end

  // Cuts a hang short well past the expected run length.
  initial begin
    #40000;
    bad_count++;
    tally_and_finish();
  end
endmodule
